// ===== core/sbmps_uart.sv
// Asynchronous serial interface with fine prescalers, muting, parity and 16x sampling.
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "sbmps_consts.svh"

module sbmps_uart (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Register port.
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Power modes and events.
  input wire logic halt,
  output logic irq,
  // Serial line.
  input wire logic rx_line,
  output logic tx_line
);

  sbmps_pkg::sbmps_state_t s;
  sbmps_pkg::sbmps_state_t next_s;
  sbmps_pkg::sbmps_bus_t bus;

  // Register map, by index on the three-bit address.
  // Index 0 is control one: received bit 8 reads in bit 7, transmit bit 8 in bit 6,
  // word length in bit 4, wake method in bit 3, parity enable in bit 2, parity odd in bit 1
  // and the parity interrupt enable in bit 0.
  // Index 1 is control two: four interrupt enables on top, then transmit enable,
  // receive enable and the mute request.
  // Index 2 is status, read only: transmit empty, transmit done, receive full, idle,
  // overrun, noise, frame and parity fault, from the top bit down.
  // Index 3 is data: a write starts a transmission, a read clears every receive flag.
  // Index 4 holds the conventional dividers, indices 5 and 6 the fine dividers.
  // Unmapped indices read as zero and ignore writes, so software probing is harmless.
  // Read data stands for exactly one cycle and is zero otherwise, which lets several
  // slaves share one read bus by a plain OR.

  // Conventional prescaler decode: shared 1,3,4,13 and direction powers of two.
  function automatic logic [15:0] conv_div(input logic [1:0] pr, input logic [2:0] dr);
    logic [7:0] p;
    p = (pr == 2'h0) ? 8'h01 : (pr == 2'h1) ? 8'h03 : (pr == 2'h2) ? 8'h04 : 8'h0D;
    conv_div = {8'h00, p} << dr;
  endfunction

  // Clock cycles per sample tick of the 16x stage, including the fine factor when nonzero.
  // A zero fine divider counts as one, so the conventional rate is kept unchanged.
  // The product is cut to sixteen bits; large settings such as 1664 times 255 overflow and wrap.
  function automatic logic [15:0] tick_len(input logic [15:0] conv, input logic [7:0] fine);
    logic [23:0] prod;
    prod = {8'h00, conv} * {16'h0000, (fine == 8'h00) ? 8'h01 : fine};
    tick_len = prod[15:0];
  endfunction

  assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // Every register runs each clock; the next state is built below.
  // Reset puts both lines and the synchroniser at the idle level, so no false start
  // edge is seen when reset is released.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s <= '0;
      s.tx_empty <= 1'b1;
      s.tx_done <= 1'b1;
      s.rx_sync <= 3'h7;
      s.rx_pin <= 1'b1;
      s.rx_hist <= 3'h7;
      s.tx_pin <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign irq = s.irq;
  assign tx_line = s.tx_pin;

  // Whole-block next state; halt freezes everything except the pin synchroniser, the sample tick and the read data, which fall to zero.
  always_comb
  begin
    logic [15:0] rxl;
    logic [15:0] txl;
    logic maj;
    logic w9;
    logic parity_enable;
    logic [8:0] word;
    logic par;
    logic mute;
    logic mark;
    next_s = s;
    rxl = tick_len(conv_div(s.baud[7:6], s.baud[2:0]), s.rx_fine_divider_reg);
    txl = tick_len(conv_div(s.baud[7:6], s.baud[5:3]), s.tx_fine_divider_reg);
    maj = 1'b0;
    w9 = 1'b0;
    parity_enable = 1'b0;
    word = 9'h000;
    par = 1'b0;
    mark = 1'b0;
    mute = s.ctrl2[`SBMPS_C2_MUTE];
    next_s.rx_sync = {s.rx_sync[1:0], rx_line};
    if (s.rx_sync[2] == s.rx_sync[1])
      next_s.rx_pin = s.rx_sync[1];
    next_s.rx_tick = 1'b0;
    next_s.rdata = 8'h00;
    if (!halt)
    begin
      // Register reads; a data read alone clears the receive flags, no status read first.
      if (bus.rd)
      begin
        case (bus.addr)
          `SBMPS_ADDR_CTRL1: next_s.rdata = {s.rx_word[8], s.ctrl1[6:0]};
          `SBMPS_ADDR_CTRL2: next_s.rdata = s.ctrl2;
          `SBMPS_ADDR_STATUS: next_s.rdata = {s.tx_empty, s.tx_done, s.rx_full_flag,
            s.idle_flag, s.overrun_flag, s.noise_flag, s.frame_flag, s.parity_fault_flag};
          `SBMPS_ADDR_DATA:
          begin
            next_s.rdata = s.rx_word[7:0];
            next_s.rx_full_flag = 1'b0;
            next_s.idle_flag = 1'b0;
            next_s.overrun_flag = 1'b0;
            next_s.noise_flag = 1'b0;
            next_s.frame_flag = 1'b0;
            next_s.parity_fault_flag = 1'b0;
          end
          `SBMPS_ADDR_BAUD: next_s.rdata = s.baud;
          `SBMPS_ADDR_TXFINE: next_s.rdata = s.tx_fine_divider_reg;
          `SBMPS_ADDR_RXFINE: next_s.rdata = s.rx_fine_divider_reg;
          default: next_s.rdata = 8'h00;
        endcase
      end
      // Register writes; a control two write may re-arm mute, which software avoids.
      if (bus.wr)
      begin
        case (bus.addr)
          `SBMPS_ADDR_CTRL1: next_s.ctrl1 = bus.wdata;
          `SBMPS_ADDR_CTRL2: next_s.ctrl2 = bus.wdata;
          `SBMPS_ADDR_DATA:
          begin
            next_s.tx_hold = {s.ctrl1[6], bus.wdata};
            next_s.tx_empty = 1'b0;
            next_s.tx_done = 1'b0;
          end
          `SBMPS_ADDR_BAUD: next_s.baud = bus.wdata;
          `SBMPS_ADDR_TXFINE: next_s.tx_fine_divider_reg = bus.wdata;
          `SBMPS_ADDR_RXFINE: next_s.rx_fine_divider_reg = bus.wdata;
          default: next_s.baud = s.baud;
        endcase
      end

      // The receive and transmit dividers run independently, so each direction may use
      // its own fine factor and its own power-of-two divider.
      // The comparison uses greater-or-equal rather than equality: should a divider be
      // shortened while a count is above the new end, the count wraps at once instead of
      // running through the full sixteen-bit range.
      // Changing dividers mid-frame still distorts that frame; software keeps them still
      // while a direction is enabled.
      // Receive sample tick at 16x the receive bit rate.
      if (s.rx_div >= rxl - 16'h0001)
      begin
        next_s.rx_div = 16'h0000;
        next_s.rx_tick = 1'b1;
      end
      else
        next_s.rx_div = s.rx_div + 16'h0001;

      // Sample numbering: the tick that sees the start edge is sample 1, so a phase value
      // of n takes sample n plus one.
      // Samples 8, 9 and 10 are kept in a three-bit history; the majority of them is the
      // bit value and any disagreement marks noise.
      // The phase is realigned at each start edge, so timing error cannot pile up from one
      // frame to the next.
      // A start whose middle samples vote high is treated as a false start and the frame
      // is dropped; the receiver goes back to hunting for an edge.
      // Format, parity sense and word length are latched at the start edge, so changes
      // made by software take effect only from the next frame.
      // Receiver: one sample per tick, phase reset at each start edge.
      if (s.rx_tick && s.ctrl2[`SBMPS_C2_RE])
      begin
        next_s.rx_hist = {s.rx_hist[1:0], s.rx_pin};
        next_s.rx_phase = s.rx_phase + 4'h1;
        if (s.rx_phase >= `SBMPS_MID_A && s.rx_phase <= `SBMPS_MID_C)
          next_s.rx_mids = {s.rx_mids[1:0], s.rx_pin};
        maj = (s.rx_mids[0] & s.rx_mids[1]) | (s.rx_mids[0] & s.rx_mids[2])
          | (s.rx_mids[1] & s.rx_mids[2]);
        w9 = s.rx_w9;
        parity_enable = s.rx_pce;
        case (s.rx_state)
          sbmps_pkg::RX_IDLE:
          begin
            // Ten high bits in a row form an idle frame.
            if (s.rx_pin)
            begin
              if (s.rx_phase == `SBMPS_OVERSAMPLE)
                next_s.idle_cnt = s.idle_cnt + 4'h1;
              if (s.idle_cnt == 4'hA && s.idle_armed)
              begin
                next_s.idle_armed = 1'b0;
                next_s.idle_cnt = 4'h0;
                if (mute && !s.ctrl1[`SBMPS_C1_WAKE])
                  next_s.ctrl2[`SBMPS_C2_MUTE] = 1'b0;
                else if (!mute)
                  next_s.idle_flag = 1'b1;
              end
            end
            else
            begin
              next_s.rx_state = sbmps_pkg::RX_START;
              next_s.rx_phase = 4'h1;
              next_s.rx_noise = s.rx_hist != 3'h7;
              next_s.rx_w9 = s.ctrl1[`SBMPS_C1_WORD9];
              next_s.rx_pce = s.ctrl1[`SBMPS_C1_PCE];
              next_s.rx_odd = s.ctrl1[`SBMPS_C1_PS];
              next_s.rx_bits = 4'h0;
            end
          end
          sbmps_pkg::RX_START:
          begin
            if ((s.rx_phase == 4'h2 || s.rx_phase == 4'h4 || s.rx_phase == 4'h6) && s.rx_pin)
              next_s.rx_noise = 1'b1;
            if (s.rx_phase == 4'hA && s.rx_mids != 3'h0)
            begin
              next_s.rx_noise = 1'b1;
              if (maj)
                next_s.rx_state = sbmps_pkg::RX_IDLE;
            end
            if (s.rx_phase == `SBMPS_OVERSAMPLE)
            begin
              next_s.rx_state = sbmps_pkg::RX_DATA;
              next_s.rx_phase = 4'h0;
            end
          end
          sbmps_pkg::RX_DATA:
          begin
            if (s.rx_phase == 4'hA)
            begin
              next_s.rx_shift = {maj, s.rx_shift[9:1]};
              next_s.rx_bits = s.rx_bits + 4'h1;
              if (s.rx_mids != 3'h0 && s.rx_mids != 3'h7)
                next_s.rx_noise = 1'b1;
            end
            if (s.rx_phase == `SBMPS_OVERSAMPLE && s.rx_bits == (w9 ? 4'h9 : 4'h8))
            begin
              next_s.rx_state = sbmps_pkg::RX_STOP;
              next_s.rx_phase = 4'h0;
            end
          end
          sbmps_pkg::RX_STOP:
          begin
            if (s.rx_phase == 4'hA)
            begin
              next_s.rx_state = sbmps_pkg::RX_IDLE;
              next_s.rx_phase = 4'h0;
              next_s.idle_cnt = 4'h0;
              next_s.idle_armed = 1'b1;
              word = w9 ? s.rx_shift[9:1] : {1'b0, s.rx_shift[9:2]};
              par = (w9 ? ^word[8:0] : ^word[7:0]) ^ s.rx_odd;
              // With parity on, the top place carries parity, so the mark is the bit below.
              mark = parity_enable ? (w9 ? word[7] : word[6]) : (w9 ? word[8] : word[7]);
              if (mute && s.ctrl1[`SBMPS_C1_WAKE] && mark)
                next_s.ctrl2[`SBMPS_C2_MUTE] = 1'b0;
              if (!mute || (s.ctrl1[`SBMPS_C1_WAKE] && mark))
              begin
                if (s.rx_full_flag)
                  next_s.overrun_flag = 1'b1;
                else
                begin
                  next_s.rx_word = word;
                  next_s.rx_full_flag = 1'b1;
                  next_s.noise_flag = s.rx_noise | (s.rx_mids != 3'h7 && s.rx_mids != 3'h0);
                  next_s.frame_flag = !maj;
                  next_s.parity_fault_flag = parity_enable & par;
                end
              end
            end
          end
          default: next_s.rx_state = sbmps_pkg::RX_IDLE;
        endcase
      end

      // The transmitter loads its shift register straight from the holding word when it
      // is idle and enabled; there is no second buffer, so software waits for the empty
      // flag before writing the next word.
      // Parity, when enabled, takes the top place of the frame and replaces the bit that
      // software wrote there.
      // The line shows each bit one cycle after the shift, a fixed latency that does not
      // change the bit length.
      // Transmit tick and bit timing at 16 ticks per bit.
      if (s.tx_div >= txl - 16'h0001)
      begin
        next_s.tx_div = 16'h0000;
        next_s.tx_sub = s.tx_sub + 4'h1;
      end
      else
        next_s.tx_div = s.tx_div + 16'h0001;
      case (s.tx_state)
        sbmps_pkg::TX_IDLE:
        begin
          next_s.tx_pin = 1'b1;
          if (!s.tx_empty && s.ctrl2[`SBMPS_C2_TE])
          begin
            word = s.tx_hold;
            parity_enable = s.ctrl1[`SBMPS_C1_PCE];
            w9 = s.ctrl1[`SBMPS_C1_WORD9];
            par = (w9 ? ^word[7:0] : ^word[6:0]) ^ s.ctrl1[`SBMPS_C1_PS];
            if (parity_enable && w9)
              word[8] = par;
            else if (parity_enable)
              word[7] = par;
            next_s.tx_shift = w9 ? {1'b1, word, 1'b0} : {2'b11, word[7:0], 1'b0};
            next_s.tx_bits = w9 ? 4'hB : 4'hA;
            next_s.tx_empty = 1'b1;
            next_s.tx_div = 16'h0000;
            next_s.tx_sub = 4'h0;
            next_s.tx_state = sbmps_pkg::TX_SEND;
          end
        end
        sbmps_pkg::TX_SEND:
        begin
          next_s.tx_pin = s.tx_shift[0];
          if (s.tx_sub == `SBMPS_OVERSAMPLE && s.tx_div >= txl - 16'h0001)
          begin
            next_s.tx_shift = {1'b1, s.tx_shift[10:1]};
            next_s.tx_bits = s.tx_bits - 4'h1;
            if (s.tx_bits == 4'h1)
            begin
              next_s.tx_done = 1'b1;
              next_s.tx_state = sbmps_pkg::TX_IDLE;
            end
          end
        end
        default: next_s.tx_state = sbmps_pkg::TX_IDLE;
      endcase

      // Noise and frame errors raise no request of their own; they arrive together with
      // receive full, which does.
      // While muted, every receive request is held off, but transmit requests still pass.
      // The request is registered, so it appears one cycle after the flag that causes it.
      // Event output; used as the wait-mode wake request.
      next_s.irq = (s.ctrl2[`SBMPS_C2_TIE] & s.tx_empty)
        | (s.ctrl2[`SBMPS_C2_TCIE] & s.tx_done)
        | (!mute & s.ctrl2[`SBMPS_C2_RIE] & (s.rx_full_flag | s.overrun_flag))
        | (!mute & s.ctrl2[`SBMPS_C2_ILIE] & s.idle_flag)
        | (!mute & s.ctrl1[`SBMPS_C1_PIE] & s.parity_fault_flag);
    end
  end

endmodule

// ===== core/sbmps_consts.svh
// Register offsets, field positions, reset values and timing counts of the serial block.
`ifndef SBMPS_CONSTS_SVH
`define SBMPS_CONSTS_SVH
`define SBMPS_ADDR_CTRL1 3'h0
`define SBMPS_ADDR_CTRL2 3'h1
`define SBMPS_ADDR_STATUS 3'h2
`define SBMPS_ADDR_DATA 3'h3
`define SBMPS_ADDR_BAUD 3'h4
`define SBMPS_ADDR_TXFINE 3'h5
`define SBMPS_ADDR_RXFINE 3'h6
`define SBMPS_C1_WORD9 4
`define SBMPS_C1_WAKE 3
`define SBMPS_C1_PCE 2
`define SBMPS_C1_PS 1
`define SBMPS_C1_PIE 0
`define SBMPS_C2_TE 3
`define SBMPS_C2_RE 2
`define SBMPS_C2_MUTE 1
`define SBMPS_C2_RIE 5
`define SBMPS_C2_ILIE 4
`define SBMPS_C2_TIE 7
`define SBMPS_C2_TCIE 6
`define SBMPS_CTRL_RESET 8'h00
`define SBMPS_OVERSAMPLE 4'hF
`define SBMPS_MID_A 4'h7
`define SBMPS_MID_C 4'h9
`endif

// ===== core/sbmps_pkg.sv
// Types shared by the serial block.
package sbmps_pkg;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} sbmps_rx_state_t;
  typedef enum {TX_IDLE, TX_SEND} sbmps_tx_state_t;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sbmps_bus_t;
  typedef struct packed {
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] baud;
    logic [7:0] tx_fine_divider_reg;
    logic [7:0] rx_fine_divider_reg;
    logic [7:0] rdata;
    logic [8:0] rx_word;
    logic rx_full_flag;
    logic idle_flag;
    logic overrun_flag;
    logic noise_flag;
    logic frame_flag;
    logic parity_fault_flag;
    logic tx_empty;
    logic tx_done;
    logic [8:0] tx_hold;
    logic [2:0] rx_sync;
    logic rx_pin;
    logic [15:0] rx_div;
    logic rx_tick;
    sbmps_rx_state_t rx_state;
    logic [3:0] rx_phase;
    logic [3:0] rx_bits;
    logic [9:0] rx_shift;
    logic [2:0] rx_hist;
    logic [2:0] rx_mids;
    logic rx_noise;
    logic rx_pce;
    logic rx_odd;
    logic rx_w9;
    logic [3:0] idle_cnt;
    logic idle_armed;
    logic [15:0] tx_div;
    logic [3:0] tx_sub;
    sbmps_tx_state_t tx_state;
    logic [10:0] tx_shift;
    logic [3:0] tx_bits;
    logic tx_pin;
    logic irq;
  } sbmps_state_t;
endpackage

// ===== verification/sbmps_uart_assertions.sv
// Checker of the serial block's port timing.
`timescale 1ns/1ps
module sbmps_uart_assertions (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Register port.
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // Modes and serial line.
  input wire logic halt,
  input wire logic irq,
  input wire logic rx_line,
  input wire logic tx_line
);
  logic [1:0] en;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // Mirrors the enable bits, so a request can be tied to the software that allowed it.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      en <= 2'b00;
    else if (wr && !halt && addr == 3'h0)
      en[0] <= wdata[0];
    else if (wr && !halt && addr == 3'h1)
      en[1] <= |wdata[7:4];
  end
  sequence s_halt2;
    halt ##1 halt;
  endsequence
  sequence s_start;
    $fell(tx_line);
  endsequence
  property p_rdata_idle;
    !rd |=> rdata == 8'h00;
  endproperty
  property p_unmapped;
    rd && !halt && addr == 3'h7 |=> rdata == 8'h00;
  endproperty
  property p_halt_read;
    rd && halt |=> rdata == 8'h00;
  endproperty
  property p_halt_tx;
    s_halt2 |-> $stable(tx_line);
  endproperty
  property p_halt_irq;
    s_halt2 |-> $stable(irq);
  endproperty
  property p_start_len;
    s_start |-> !tx_line [*8];
  endproperty
  property p_irq_enable;
    (en == 2'b00) [*3] |-> !irq;
  endproperty
  property p_reset_idle;
    $rose(rst_b) |-> tx_line && !irq;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_halt_read: assert property (p_halt_read) else $error("read answered in halt");
  a_halt_tx: assert property (p_halt_tx) else $error("line moved in halt");
  a_halt_irq: assert property (p_halt_irq) else $error("irq moved in halt");
  a_start_len: assert property (p_start_len) else $error("start bit too short");
  a_irq_enable: assert property (p_irq_enable) else $error("irq without enable");
  a_reset_idle: assert property (p_reset_idle) else $error("line not idle");
endmodule

bind sbmps_uart sbmps_uart_assertions i_chk (.clock, .rst_b, .addr, .wdata, .wr, .rd, .rdata,
  .halt, .irq, .rx_line, .tx_line);

// ===== verification/sbmps_remote.sv
// Remote transmitter model that drives the block's receive line.
`timescale 1ns/1ps
module sbmps_remote (
  // Clock and frame request.
  input wire logic clock,
  input wire logic go,
  input wire logic [8:0] word,
  input wire logic [3:0] nbits,
  input wire logic [15:0] period,
  input wire logic [3:0] gbit,
  // Line side.
  output logic line,
  output logic busy
);
  logic v;
  initial line = 1'b1;
  initial busy = 1'b0;
  // Sends one frame at an exact rate; the pulled-up line rests high between frames.
  // A gbit match flips one sample period mid-bit, so only one of three samples sees it.
  always @(posedge clock)
  begin
    if (go)
    begin
      busy <= 1'b1;
      for (int b = 0; b < nbits + 2; b++)
      begin
        v = (b == 0) ? 1'b0 : (b > nbits) ? 1'b1 : word[b - 1];
        for (int c = 0; c < period; c++)
        begin
          line <= (b == gbit && c >= period / 2 && c < period * 9 / 16) ? ~v : v;
          @(posedge clock);
        end
      end
      line <= 1'b1;
      busy <= 1'b0;
    end
  end
endmodule

// ===== verification/tb_sbmps_uart.sv
// Self-checking bench of the serial block.
`timescale 1ns/1ps
module tb_sbmps_uart;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic halt = 1'b0;
  logic go = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic [8:0] word = 9'h000;
  logic [3:0] nbits = 4'h8;
  logic [3:0] gbit = 4'hF;
  logic [7:0] r, lf, m;
  logic [10:0] bits, got;
  logic irq, rx_line, tx_line, busy;
  int failures = 0;
  int checks_done = 0;
  int n, i, k, per;
  sbmps_uart i_dut (.clock, .rst_b, .addr, .wdata, .wr, .rd, .rdata(r), .halt, .irq, .rx_line,
    .tx_line);
  sbmps_remote i_far (.clock, .go, .word, .nbits, .period(16'h0020), .gbit, .line(rx_line),
    .busy);
  // Free-running system clock.
  initial
  begin
    forever #25 clock = ~clock;
  end
  task automatic check(input string s, input logic [10:0] seen, input logic [10:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // Read data is taken in the one cycle where it stands.
  task automatic rd_reg(input logic [2:0] a);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
  endtask
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // Whole frame LSB first: start, data with parity in the top place, stop, then idle for eight-bit words.
  function automatic logic [10:0] frame(input logic [8:0] d, input logic w9, input logic p,
    input logic ps);
    logic [8:0] w;
    w = d;
    if (p)
      w[w9 ? 8 : 7] = ^(w9 ? d[7:0] : {1'b0, d[6:0]}) ^ ps;
    return w9 ? {1'b1, w, 1'b0} : {2'b11, w[7:0], 1'b0};
  endfunction
  task automatic rx_frame(input logic [8:0] w, input logic w9, input logic [3:0] g);
    @(posedge clock);
    word <= w;
    nbits <= w9 ? 4'h9 : 4'h8;
    gbit <= g;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
    for (n = 0; n < 4000 && busy; n++)
      @(posedge clock);
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Cuts a hang short well beyond the expected run length.
  initial
  begin
    repeat (40000) @(posedge clock);
    failures++;
    wrap_up();
  end
  initial
  begin
    lf = 8'h63;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    rd_reg(3'h2);
    check("status", r, 8'hC0);
    rd_reg(3'h7);
    check("unmapped", r, 8'h00);
    // Every frame format is sent, the first at the conventional rate.
    for (k = 0; k < 4; k++)
    begin
      lf = lfsr(lf);
      per = (k == 0) ? 1 : 3;
      bits = frame({lf[1], lf}, k[1], k[0], lf[0]);
      wr_reg(3'h1, 8'h00);
      wr_reg(3'h5, (k == 0) ? 8'h00 : 8'h03);
      wr_reg(3'h0, {1'b0, lf[1], 1'b0, k[1], 1'b0, k[0], lf[0], 1'b0});
      wr_reg(3'h1, 8'h08);
      wr_reg(3'h3, lf);
      for (n = 0; n < 4000 && tx_line; n++)
        @(negedge clock);
      repeat (8 * per) @(negedge clock);
      for (i = 0; i < 11; i++)
      begin
        got[i] = tx_line;
        repeat (16 * per) @(negedge clock);
      end
      check("tx frame", got, bits);
    end
    wr_reg(3'h3, 8'h00);
    for (n = 0; n < 4000 && tx_line; n++)
      @(negedge clock);
    @(posedge clock);
    halt <= 1'b1;
    repeat (200) @(negedge clock);
    check("halt line", tx_line, 1'b0);
    rd_reg(3'h2);
    check("halt read", r, 8'h00);
    @(posedge clock);
    halt <= 1'b0;
    repeat (600) @(posedge clock);
    wr_reg(3'h1, 8'h00);
    wr_reg(3'h6, 8'h02);
    wr_reg(3'h1, 8'h24);
    for (k = 0; k < 4; k++)
    begin
      lf = lfsr(lf);
      m = (k == 1) ? 8'h7F : 8'hFF;
      bits = frame({lf[2], lf}, k[1], k[0], lf[0]);
      wr_reg(3'h0, {3'b000, k[1], 1'b0, k[0], lf[0], 1'b0});
      rx_frame(bits[9:1], k[1], 4'hF);
      rd_reg(3'h2);
      check("rx status", r[5:0], 6'h20);
      rd_reg(3'h3);
      check("rx data", r & m, bits[8:1] & m);
    end
    wr_reg(3'h1, 8'h04);
    wr_reg(3'h0, 8'h05);
    bits = frame({1'b0, lf}, 1'b0, 1'b1, 1'b0) ^ 11'h100;
    rx_frame(bits[9:1], 1'b0, 4'hF);
    rd_reg(3'h2);
    check("parity fault", r[5:0], 6'h21);
    check("parity irq", irq, 1'b1);
    rd_reg(3'h3);
    wr_reg(3'h0, 8'h00);
    rx_frame({1'b0, lf}, 1'b0, 4'h3);
    rd_reg(3'h2);
    check("noise", r[5:0], 6'h24);
    rd_reg(3'h3);
    check("noisy data", r, lf);
    wr_reg(3'h0, 8'h08);
    wr_reg(3'h1, 8'h06);
    rx_frame(9'h012, 1'b0, 4'hF);
    rd_reg(3'h2);
    check("muted", r[5:0], 6'h00);
    rx_frame(9'h093, 1'b0, 4'hF);
    rd_reg(3'h2);
    check("mark wake", r[5], 1'b1);
    rd_reg(3'h1);
    check("mark mute", r[1], 1'b0);
    rd_reg(3'h3);
    check("mark data", r, 8'h93);
    wr_reg(3'h0, 8'h00);
    wr_reg(3'h1, 8'h06);
    rx_frame(9'h055, 1'b0, 4'hF);
    repeat (384) @(posedge clock);
    rd_reg(3'h1);
    check("idle wake", r[1], 1'b0);
    rd_reg(3'h2);
    check("idle flag", r[5:4], 2'b00);
    wrap_up();
  end
endmodule
